// file: hbdm_defs.svh
// constant definitions for the host bus dma master
`ifndef HBDM_DEFS_SVH
`define HBDM_DEFS_SVH

// ==========================================================
// widths and field positions
`define HBDM_AW        24
`define HBDM_DW        16
`define HBDM_CW        16
`define HBDM_EXT_MSB   23
`define HBDM_EXT_LSB   16
`define HBDM_MID_MSB   15
`define HBDM_MID_LSB   8
`define HBDM_LOW_MSB   7
`define HBDM_LOW_LSB   0
`define HBDM_LOW_BITS  8

// ==========================================================
// reset values and steps
`define HBDM_ADDR_RST  24'h000000
`define HBDM_CNT_RST   16'h0000
`define HBDM_DATA_RST  16'h0000
`define HBDM_BYTE_RST  8'h00
`define HBDM_CNT_ONE   16'h0001
`define HBDM_STEP_8    24'h000001
`define HBDM_STEP_16   24'h000002

// ==========================================================
// strobe levels, active low on the host bus
`define HBDM_STB_ON    1'b0
`define HBDM_STB_OFF   1'b1

`endif

// file: hbdm_pkg.sv
// types shared by the host bus dma master
package hbdm_pkg;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		HBDM_IDLE = 4'b0000,
		HBDM_ARB  = 4'b0001,
		HBDM_REQD = 4'b0010,
		HBDM_REQ  = 4'b0011,
		HBDM_PRE  = 4'b0100,
		HBDM_TX   = 4'b0101,
		HBDM_T1   = 4'b0110,
		HBDM_T2   = 4'b0111,
		HBDM_T3   = 4'b1000,
		HBDM_T4   = 4'b1001,
		HBDM_I1   = 4'b1010,
		HBDM_I2   = 4'b1011
	} hbdm_state_t;

endpackage

// file: hbdm_addr_step.sv
// address increment with carry out of the low address byte
`timescale 1ns/10ps
`default_nettype none
`include "hbdm_defs.svh"
module hbdm_addr_step (
	input  wire logic [`HBDM_AW-1:0] addr_in,
	input  wire logic                bus8_in,
	output logic      [`HBDM_AW-1:0] addr_next_out,
	output logic                     carry_low_out
);
	import hbdm_pkg::*;

	// ==========================================================
	// add and flag a carry past the low byte
	function automatic logic [`HBDM_AW:0] hbdm_add(input logic [`HBDM_AW-1:0] a,
		input logic [`HBDM_AW-1:0] s);
		hbdm_add = {1'b0, a} + {1'b0, s};
	endfunction

	logic [`HBDM_AW:0] sum;

	always_comb begin
		sum = hbdm_add(addr_in, bus8_in ? `HBDM_STEP_8 : `HBDM_STEP_16);
		addr_next_out = sum[`HBDM_AW-1:0];
		carry_low_out = (sum[`HBDM_AW-1:`HBDM_LOW_BITS] != addr_in[`HBDM_AW-1:`HBDM_LOW_BITS]);
	end

endmodule
`default_nettype wire

// file: hbdm_master.sv
// host bus dma master: arbitration, transfer states and release
`timescale 1ns/10ps
`default_nettype none
`include "hbdm_defs.svh"
// Notes on behaviour
// - while owning the bus, the select input is ignored for slave access.
// - cycle-steal transfers always carry the extended address state.
// - burst inserts extended address on first transfer and low-byte carry.
// - without extended state, address and data strobes assert in state one.
// - extended state drives the top address byte on the high byte lines.
// - 8-bit separate strobe mode ignores the shared pin, drives it high in DMA.
// - 8-bit mode holds middle address byte on high lines through states 2-4.
// - strobes are driven high from the extended state of the first transfer until first asserted.
// - separate strobe mode drops request on edge after last state four.
// - data strobe mode drops request in state two of first transfer.
// - request rises on the second edge after sampling grant low.
// - data strobe mode never checks that acknowledge was removed.
// - release request is ignored when the bus is not owned.
// - release while owned finishes the started cycle, then frees the bus.
// - release with no transfer started frees the bus without a transfer.
// - release before state one makes this cycle the last one.
// - release after state one allows this cycle and one more.
// - the request is removed in the exchange idle state.
// - owned flag rises cycle before first state, falls second cycle after four.
// - a bus error completes the transfer without acknowledge, then releases.
// - after a bus error all host and LAN side DMA halts.
// - bus error is ignored outside DMA transfer states.
module hbdm_master (
	input  wire logic                clk_sys_in,
	input  wire logic                sys_rst_in,
	input  wire logic                dma_start_in,
	input  wire logic [`HBDM_AW-1:0] start_addr_in,
	input  wire logic [`HBDM_CW-1:0] xfer_count_in,
	input  wire logic                dir_write_in,
	input  wire logic                burst_mode_in,
	input  wire logic                sep_strobe_mode_in,
	input  wire logic                bus8_mode_in,
	input  wire logic [`HBDM_DW-1:0] wr_data_in,
	output logic      [`HBDM_DW-1:0] rd_data_out,
	output logic                     xfer_done_out,
	output logic                     dma_busy_out,
	output logic                     error_halt_out,
	output logic                     lan_dma_stop_out,
	input  wire logic                device_select_in,
	output logic                     slave_select_out,
	output logic                     bus_owned_out,
	output logic                     hold_request_out,
	input  wire logic                hold_grant_in,
	input  wire logic                transfer_ack_in,
	input  wire logic                release_request_in,
	input  wire logic                bus_error_in,
	input  wire logic [`HBDM_DW-1:0] ad_in,
	output logic      [`HBDM_LOW_MSB:0] addr_data_high_byte_out,
	output logic                     addr_data_high_byte_oe_out,
	output logic      [`HBDM_LOW_MSB:0] addr_data_low_byte_out,
	output logic                     addr_data_low_byte_oe_out,
	input  wire logic                high_byte_or_direction_in,
	output logic                     high_byte_or_direction_out,
	output logic                     high_byte_or_direction_oe_out,
	output logic                     memory_addr_strobe_n_out,
	output logic                     upper_data_strobe_n_out,
	output logic                     lower_data_strobe_n_out,
	output logic                     strobe_oe_out
);
	import hbdm_pkg::*;

	// ==========================================================
	// state
	hbdm_state_t            state_reg;
	hbdm_state_t            state_next;
	logic [`HBDM_AW-1:0]    addr_reg;
	logic [`HBDM_AW-1:0]    addr_step;
	logic [`HBDM_AW-1:0]    addr_cur;
	logic                   carry_low;
	logic [`HBDM_CW-1:0]    left_reg;
	logic                   first_reg;
	logic                   rel_last_reg;
	logic                   rel_extra_reg;
	logic                   err_seen_reg;
	logic                   halt_reg;
	logic                   owned_next;
	logic                   stb_next;
	logic                   in_xfer;
	logic                   want_tx;
	logic                   stop_now;

	hbdm_addr_step u_step (
		.addr_in       (addr_reg),
		.bus8_in       (bus8_mode_in),
		.addr_next_out (addr_step),
		.carry_low_out (carry_low)
	);

	assign in_xfer = (state_reg >= HBDM_TX) && (state_reg <= HBDM_T4);
	assign addr_cur = (state_reg == HBDM_T4) ? addr_step : addr_reg; // register steps on that edge
	assign want_tx = !burst_mode_in || carry_low;
	assign stop_now = halt_reg || err_seen_reg || bus_error_in || rel_last_reg ||
		(left_reg == `HBDM_CNT_ONE);

	// ==========================================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			HBDM_IDLE: begin
				if (dma_start_in && !halt_reg && (xfer_count_in != `HBDM_CNT_RST)) begin
					state_next = HBDM_ARB;
				end
			end
			HBDM_ARB: begin
				if (!hold_grant_in) begin // grant low first, also after release
					state_next = HBDM_REQD;
				end
			end
			HBDM_REQD: state_next = HBDM_REQ;
			HBDM_REQ: begin
				if (hold_grant_in) begin
					state_next = HBDM_PRE;
				end
			end
			HBDM_PRE: begin
				if (release_request_in) begin
					state_next = HBDM_I1;
				end else begin
					state_next = HBDM_TX; // first transfer always extended
				end
			end
			HBDM_TX: state_next = HBDM_T1;
			HBDM_T1: state_next = HBDM_T2;
			HBDM_T2: state_next = HBDM_T3;
			HBDM_T3: begin
				if (transfer_ack_in || bus_error_in || err_seen_reg) begin
					state_next = HBDM_T4;
				end
			end
			HBDM_T4: begin
				if (stop_now) begin // no wait for acknowledge removal
					state_next = HBDM_I1;
				end else if (want_tx) begin
					state_next = HBDM_TX;
				end else begin
					state_next = HBDM_T1;
				end
			end
			HBDM_I1: state_next = HBDM_I2;
			HBDM_I2: state_next = HBDM_IDLE;
			default: state_next = HBDM_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_reg <= HBDM_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// address, count and first-transfer tracking
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			addr_reg <= `HBDM_ADDR_RST;
			left_reg <= `HBDM_CNT_RST;
			first_reg <= 1'b0;
		end else if (state_reg == HBDM_IDLE && state_next == HBDM_ARB) begin
			addr_reg <= start_addr_in;
			left_reg <= xfer_count_in;
			first_reg <= 1'b1;
		end else if (state_reg == HBDM_T4) begin
			addr_reg <= addr_step;
			left_reg <= left_reg - `HBDM_CNT_ONE;
			first_reg <= 1'b0;
		end
	end

	// ==========================================================
	// release handling
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || state_reg == HBDM_IDLE) begin
			rel_last_reg <= 1'b0;
			rel_extra_reg <= 1'b0;
		end else if (bus_owned_out) begin
			if (release_request_in && state_reg == HBDM_TX) begin
				rel_last_reg <= 1'b1;
			end else if (state_reg == HBDM_T4 && (rel_extra_reg || release_request_in)) begin
				rel_last_reg <= 1'b1;
				rel_extra_reg <= 1'b0;
			end else if (release_request_in && in_xfer && !rel_last_reg) begin
				rel_extra_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// bus error; halts everything until reset
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			err_seen_reg <= 1'b0;
			halt_reg <= 1'b0;
		end else begin
			if (in_xfer && bus_error_in) begin
				err_seen_reg <= 1'b1;
			end else if (state_reg == HBDM_I2) begin
				err_seen_reg <= 1'b0;
			end
			if ((in_xfer && bus_error_in) || err_seen_reg) begin
				halt_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// arbitration and ownership pins
	assign owned_next = (state_next >= HBDM_PRE) && (state_next <= HBDM_I1);

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bus_owned_out <= 1'b0;
			hold_request_out <= 1'b0;
			slave_select_out <= 1'b0;
		end else begin
			bus_owned_out <= owned_next;
			slave_select_out <= device_select_in && !owned_next;
			if (state_next == HBDM_REQ) begin
				hold_request_out <= 1'b1;
			end else if (state_next == HBDM_I1 || state_next == HBDM_IDLE) begin
				hold_request_out <= 1'b0;
			end else if (!sep_strobe_mode_in && state_next == HBDM_T2 && first_reg) begin
				hold_request_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// strobes; no extended state means assertion already in state one
	assign stb_next = (state_next == HBDM_T2) || (state_next == HBDM_T3) ||
		(state_next == HBDM_T1 && state_reg != HBDM_TX);

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			memory_addr_strobe_n_out <= `HBDM_STB_OFF;
			upper_data_strobe_n_out <= `HBDM_STB_OFF;
			lower_data_strobe_n_out <= `HBDM_STB_OFF;
			strobe_oe_out <= 1'b0;
		end else begin
			strobe_oe_out <= owned_next && (state_next != HBDM_PRE); // high until asserted
			memory_addr_strobe_n_out <= stb_next ? `HBDM_STB_ON : `HBDM_STB_OFF;
			upper_data_strobe_n_out <= (stb_next && !bus8_mode_in) ? `HBDM_STB_ON :
				`HBDM_STB_OFF;
			lower_data_strobe_n_out <= stb_next ? `HBDM_STB_ON : `HBDM_STB_OFF;
		end
	end

	// ==========================================================
	// address and data lines
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			addr_data_high_byte_out <= `HBDM_BYTE_RST;
			addr_data_low_byte_out <= `HBDM_BYTE_RST;
			addr_data_high_byte_oe_out <= 1'b0;
			addr_data_low_byte_oe_out <= 1'b0;
		end else begin
			case (state_next)
				HBDM_TX: begin
					addr_data_high_byte_out <= addr_cur[`HBDM_EXT_MSB:`HBDM_EXT_LSB];
					addr_data_high_byte_oe_out <= 1'b1;
					addr_data_low_byte_oe_out <= 1'b0;
				end
				HBDM_T1: begin
					addr_data_high_byte_out <= addr_cur[`HBDM_MID_MSB:`HBDM_MID_LSB];
					addr_data_low_byte_out <= addr_cur[`HBDM_LOW_MSB:`HBDM_LOW_LSB];
					addr_data_high_byte_oe_out <= 1'b1;
					addr_data_low_byte_oe_out <= 1'b1;
				end
				HBDM_T2, HBDM_T3, HBDM_T4: begin
					addr_data_high_byte_out <= bus8_mode_in ? // 8-bit keeps address
						addr_reg[`HBDM_MID_MSB:`HBDM_MID_LSB] : wr_data_in[`HBDM_MID_MSB:`HBDM_MID_LSB];
					addr_data_low_byte_out <= wr_data_in[`HBDM_LOW_MSB:`HBDM_LOW_LSB];
					addr_data_high_byte_oe_out <= bus8_mode_in || dir_write_in;
					addr_data_low_byte_oe_out <= dir_write_in;
				end
				default: begin
					addr_data_high_byte_oe_out <= 1'b0;
					addr_data_low_byte_oe_out <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// shared byte-enable / direction pin
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			high_byte_or_direction_out <= 1'b1;
			high_byte_or_direction_oe_out <= 1'b0;
		end else begin
			high_byte_or_direction_oe_out <= owned_next;
			if (sep_strobe_mode_in) begin
				high_byte_or_direction_out <= bus8_mode_in;
			end else begin
				high_byte_or_direction_out <= !dir_write_in;
			end
		end
	end

	// ==========================================================
	// user side results
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rd_data_out <= `HBDM_DATA_RST;
			xfer_done_out <= 1'b0;
			dma_busy_out <= 1'b0;
			error_halt_out <= 1'b0;
			lan_dma_stop_out <= 1'b0;
		end else begin
			xfer_done_out <= (state_reg == HBDM_T3) && (state_next == HBDM_T4);
			if (state_reg == HBDM_T3 && state_next == HBDM_T4 && !dir_write_in) begin
				rd_data_out <= ad_in;
			end
			dma_busy_out <= (state_next != HBDM_IDLE);
			error_halt_out <= halt_reg;
			lan_dma_stop_out <= halt_reg;
		end
	end

	// ==========================================================
	// checks
	chk_select_blocked: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		bus_owned_out |-> !slave_select_out)
		else $error("slave select seen while bus owned");
	chk_steal_ext: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_T4 && !burst_mode_in && !stop_now) |=> state_reg == HBDM_TX)
		else $error("cycle steal transfer without extended state");
	chk_burst_noext: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_T4 && burst_mode_in && !carry_low && !stop_now)
		|=> state_reg == HBDM_T1)
		else $error("burst inserted extended state without carry");
	chk_t1_strobe: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_T4 && state_next == HBDM_T1) |=> !memory_addr_strobe_n_out)
		else $error("address strobe not asserted in state one");
	chk_ext_byte: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_next == HBDM_TX) |=> (addr_data_high_byte_oe_out &&
		addr_data_high_byte_out == addr_reg[`HBDM_EXT_MSB:`HBDM_EXT_LSB]))
		else $error("extended address byte missing");
	chk_req_delay: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_ARB && !hold_grant_in) |-> ##2 hold_request_out)
		else $error("request not raised two edges after grant low");
	chk_req_drop: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_I1) |-> !hold_request_out)
		else $error("request held in exchange idle");
	chk_owned_fall: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_T4 && state_next == HBDM_I1) |=> bus_owned_out ##1 !bus_owned_out)
		else $error("owned flag not dropped two cycles after state four");
	chk_err_release: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(state_reg == HBDM_T3 && bus_error_in) |=> state_reg == HBDM_T4 ##1 state_reg == HBDM_I1)
		else $error("bus error did not complete and release");
	chk_err_halt: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
		(in_xfer && bus_error_in) |-> ##2 (halt_reg && !(state_reg == HBDM_ARB)))
		else $error("bus error did not halt dma");

endmodule
`default_nettype wire

// file: hbdm_host_model.sv
// host bus arbiter and memory slave model for the dma master bench
`timescale 1ns/10ps
`default_nettype none
module hbdm_host_model (
	input  wire logic        clk_sys_in,
	input  wire logic        sys_rst_in,
	input  wire logic        hold_request_in,
	input  wire logic        strobe_low_in,
	input  wire logic [7:0]  ack_wait_in,
	input  wire logic        ack_sticky_in,
	input  wire logic [15:0] rd_value_in,
	output logic             hold_grant_out,
	output logic             transfer_ack_out,
	output logic [15:0]      ad_out
);
	logic [7:0] wait_reg;

	// ==========================================================
	// arbitration
	// grant trails request by a cycle, so it is low before each new request
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			hold_grant_out <= 1'b0;
		end else begin
			hold_grant_out <= hold_request_in;
		end
	end

	// ==========================================================
	// memory slave
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in || !strobe_low_in) begin
			wait_reg <= 8'h00;
		end else if (wait_reg != 8'hFF) begin
			wait_reg <= wait_reg + 8'h01;
		end
	end
	// wait of FF never answers; sticky ack never drops between transfers
	assign transfer_ack_out = ack_sticky_in ||
		(strobe_low_in && ack_wait_in != 8'hFF && wait_reg >= ack_wait_in);
	// inverse data outside ack, so a stale read cannot match
	assign ad_out = transfer_ack_out ? rd_value_in : ~rd_value_in;
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the host bus dma master
`timescale 1ns/10ps
`default_nettype none
`include "hbdm_defs.svh"
module tb;
	logic                clk_sys_in, sys_rst_in, dma_start_in, dir_write_in, burst_mode_in;
	logic                sep_strobe_mode_in, bus8_mode_in, device_select_in;
	logic                release_request_in, bus_error_in, ack_sticky, hold_grant_in;
	logic                transfer_ack_in, xfer_done_out, dma_busy_out, error_halt_out;
	logic                lan_dma_stop_out, slave_select_out, bus_owned_out, hold_request_out;
	logic                hbd_out, hbd_oe, mas_n, uds_n, lds_n, stb_oe, was_done;
	logic [`HBDM_AW-1:0] start_addr_in;
	logic [`HBDM_CW-1:0] xfer_count_in;
	logic [`HBDM_DW-1:0] wr_data_in, rd_data_out, ad_in, rd_value;
	logic [7:0]          ack_wait, hb_out;
	int                  n_errors, tests_run, n_done, cyc, last_done;
	int                  gap_q[$];
	logic                stb_q[$];

	hbdm_master uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.dma_start_in(dma_start_in), .start_addr_in(start_addr_in),
		.xfer_count_in(xfer_count_in), .dir_write_in(dir_write_in),
		.burst_mode_in(burst_mode_in), .sep_strobe_mode_in(sep_strobe_mode_in),
		.bus8_mode_in(bus8_mode_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
		.xfer_done_out(xfer_done_out), .dma_busy_out(dma_busy_out),
		.error_halt_out(error_halt_out), .lan_dma_stop_out(lan_dma_stop_out),
		.device_select_in(device_select_in), .slave_select_out(slave_select_out),
		.bus_owned_out(bus_owned_out), .hold_request_out(hold_request_out),
		.hold_grant_in(hold_grant_in), .transfer_ack_in(transfer_ack_in),
		.release_request_in(release_request_in), .bus_error_in(bus_error_in),
		.ad_in(ad_in), .addr_data_high_byte_out(hb_out),
		.addr_data_high_byte_oe_out(), .addr_data_low_byte_out(),
		.addr_data_low_byte_oe_out(), .high_byte_or_direction_in(~hbd_out),
		.high_byte_or_direction_out(hbd_out), .high_byte_or_direction_oe_out(hbd_oe),
		.memory_addr_strobe_n_out(mas_n), .upper_data_strobe_n_out(uds_n),
		.lower_data_strobe_n_out(lds_n), .strobe_oe_out(stb_oe));

	hbdm_host_model host (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.hold_request_in(hold_request_out), .strobe_low_in(!(mas_n && uds_n && lds_n)),
		.ack_wait_in(ack_wait), .ack_sticky_in(ack_sticky), .rd_value_in(rd_value),
		.hold_grant_out(hold_grant_in), .transfer_ack_out(transfer_ack_in), .ad_out(ad_in));

	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// ==========================================================
	// transfer monitor: gaps between done pulses, strobe in the cycle after
	// sampled mid-cycle, where registered outputs have settled
	always @(negedge clk_sys_in) begin
		cyc++;
		if (was_done) stb_q.push_back(lds_n);
		was_done = (xfer_done_out === 1'b1);
		if (was_done) begin
			if (n_done > 0) gap_q.push_back(cyc - last_done);
			last_done = cyc;
			n_done++;
		end
	end

	// ==========================================================
	// helpers
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chk_n(input string what, input int exp, input int got);
		tests_run++;
		if (got != exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic wait_owned(input logic lvl);
		for (int i = 0; i < 300 && bus_owned_out !== lvl; i++) tick(1);
		chk("bus_owned_out", lvl, bus_owned_out);
	endtask
	task automatic wait_pulse;
		for (int i = 0; i < 300 && xfer_done_out !== 1'b1; i++) tick(1);
		chk("xfer_done_out", 1'b1, xfer_done_out);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 400 && dma_busy_out !== 1'b0; i++) tick(1);
		chk("dma_busy_out", 1'b0, dma_busy_out);
	endtask
	task automatic start_run(input logic [23:0] a, input int c, input logic b, s, e, w);
		start_addr_in = a;
		xfer_count_in = c[15:0];
		burst_mode_in = b;
		sep_strobe_mode_in = s;
		bus8_mode_in = e;
		dir_write_in = w;
		n_done = 0;
		gap_q.delete();
		stb_q.delete();
		dma_start_in = 1'b1;
		tick(1);
		dma_start_in = 1'b0;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_first;
		release_request_in = 1'b1;
		tick(3);
		release_request_in = 1'b0;
		tick(2);
		chk("slave_select_out", 1'b1, slave_select_out);
		ack_wait = 8'h02;
		rd_value = 16'hC3A5;
		start_run(24'h5A1234, 1, 1'b1, 1'b1, 1'b0, 1'b0);
		chk("hold_request_out", 1'b0, hold_request_out);
		tick(1);
		chk("hold_request_out", 1'b0, hold_request_out);
		tick(1);
		chk("hold_request_out", 1'b1, hold_request_out);
		wait_owned(1'b1);
		chk("strobe_oe_out", 1'b0, stb_oe);
		tick(1);
		chk("high byte in extended state", 8'h5A, hb_out);
		chk("strobes on takeover", 4'hF, {stb_oe, mas_n, uds_n, lds_n});
		chk("slave_select_out", 1'b0, slave_select_out);
		wait_pulse;
		chk("rd_data_out", 16'hC3A5, rd_data_out);
		chk("hold_request_out", 1'b1, hold_request_out);
		tick(1);
		chk("hold_request_out", 1'b0, hold_request_out);
		chk("bus_owned_out", 1'b1, bus_owned_out);
		tick(1);
		chk("bus_owned_out", 1'b0, bus_owned_out);
		wait_idle;
		chk_n("transfers", 1, n_done);
	endtask
	task automatic t_burst;
		ack_wait = 8'h00;
		start_run(24'h0012FC, 4, 1'b1, 1'b1, 1'b0, 1'b1);
		wait_idle;
		chk_n("gaps", 3, gap_q.size());
		chk_n("gap 1", 4, gap_q[0]);
		chk_n("gap 2", 5, gap_q[1]);
		chk_n("gap 3", 4, gap_q[2]);
		chk("strobe in state one", 1'b0, stb_q[0]);
		chk("strobe in extended state", 1'b1, stb_q[1]);
	endtask
	task automatic t_steal8;
		start_run(24'h34AB10, 3, 1'b0, 1'b1, 1'b1, 1'b0);
		wait_pulse;
		chk("shared pin level and enable", 2'b11, {hbd_out, hbd_oe});
		chk("high byte in state four", 8'hAB, hb_out);
		wait_idle;
		chk_n("gap 1", 5, gap_q[0]);
		chk_n("gap 2", 5, gap_q[1]);
		chk("strobe in extended state", 1'b1, stb_q[0]);
	endtask
	task automatic t_strobe;
		ack_sticky = 1'b1;
		start_run(24'h000010, 3, 1'b1, 1'b0, 1'b0, 1'b1);
		wait_pulse;
		chk("hold_request_out", 1'b0, hold_request_out);
		chk("bus_owned_out", 1'b1, bus_owned_out);
		wait_idle;
		chk_n("gap 1", 4, gap_q[0]);
		chk_n("gap 2", 4, gap_q[1]);
		ack_sticky = 1'b0;
	endtask
	task automatic t_release(input int d, input int exp);
		start_run(24'h000100, 4, 1'b1, 1'b1, 1'b0, 1'b0);
		wait_owned(1'b1);
		if (d > 0) tick(d);
		release_request_in = 1'b1;
		wait_owned(1'b0);
		chk_n("transfers before release", exp, n_done);
		chk("hold_request_out", 1'b0, hold_request_out);
		release_request_in = 1'b0;
		wait_idle;
	endtask
	task automatic t_error;
		bus_error_in = 1'b1;
		tick(2);
		bus_error_in = 1'b0;
		chk("error_halt_out", 1'b0, error_halt_out);
		ack_wait = 8'hFF;
		start_run(24'h000200, 4, 1'b1, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 100 && lds_n !== 1'b0; i++) tick(1);
		tick(2);
		bus_error_in = 1'b1;
		tick(1);
		bus_error_in = 1'b0;
		tick(8);
		chk("bus_owned_out", 1'b0, bus_owned_out);
		chk("halt and lan stop", 2'b11, {error_halt_out, lan_dma_stop_out});
		chk("dma_busy_out", 1'b0, dma_busy_out);
		start_run(24'h000200, 4, 1'b1, 1'b1, 1'b0, 1'b0);
		tick(8);
		chk("hold_request_out", 1'b0, hold_request_out);
	endtask

	// ==========================================================
	// run control
	task automatic results;
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		{sys_rst_in, dma_start_in, dir_write_in, burst_mode_in, sep_strobe_mode_in} = 5'h10;
		{bus8_mode_in, device_select_in, release_request_in, bus_error_in} = 4'h4;
		ack_sticky = 1'b0;
		start_addr_in = 24'h000000;
		xfer_count_in = 16'h0000;
		wr_data_in = 16'h96E1;
		rd_value = 16'h0000;
		ack_wait = 8'h00;
		repeat (16) @(posedge clk_sys_in); // shortened: one edge resets the model
		#1;
		sys_rst_in = 1'b0; // never asserted again
		tick(300); // quiet for 3 us after reset
		t_first;
		t_burst;
		t_steal8;
		t_strobe;
		t_release(0, 0);
		t_release(1, 1);
		t_release(2, 2);
		t_release(5, 2);
		t_error;
		results();
	end

	// whole run is a few hundred cycles; the 10000-cycle limit leaves ample margin
	initial begin
		#100000;
		n_errors++;
		results();
	end
endmodule
`default_nettype wire
